// ==== design/video_overlay_compositor.sv ====
/*
 * Per-pixel compositing stage: chroma keying, alpha blending and output
 * clipping of a 4:2:2+alpha overlay onto a background image, one pair a beat.
 * Assumes settings are static or change between pixels; inputs synchronous.
 */
`default_nettype none
`include "compositor_defs.svh"
module video_overlay_compositor
   import compositor_pkg::*;
#(
   parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
   // clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_reset,
   // settings
   input  wire logic [`CTL_WIDTH-1:0]   i_unit_control_reg,
   input  wire logic [7:0]              i_alpha_zero,
   input  wire logic [7:0]              i_alpha_one,
   input  wire transparent_match_t      i_transparent_match_reg,
   input  wire match_ignore_t           i_match_ignore_reg,
   input  wire logic                    i_limit_load,
   input  wire output_limit_t           i_output_limit_reg,
   // status
   output logic [`STATUS_WIDTH-1:0]     o_output_status_reg,
   output output_limit_t                o_output_limit_reg,
   // input stream
   input  wire logic                    i_in_valid,
   output logic                         o_in_ready,
   input  wire composite_in_t           i_in_data,
   // output stream
   output logic                         o_out_valid,
   input  wire logic                    i_out_ready,
   output pixel_pair_t                  o_out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [7:0] ignore_mask(input logic [2:0] n);
      logic [2:0] k;
      k = (n > `MAX_IGNORE_LSBS) ? `MAX_IGNORE_LSBS : n;
      ignore_mask = 8'hff << k;
   endfunction : ignore_mask

   // full or coarse blend of one component
   function automatic logic [7:0] blend(input logic [7:0] alpha, input logic [7:0] ovl,
                                        input logic [7:0] img, input logic full);
      logic signed [9:0]  diff;
      logic signed [17:0] prod;
      logic [6:0]         a;
      diff = 10'(signed'({2'b00, ovl})) - 10'(signed'({2'b00, img}));
      // coarse mode keeps only the 25% step of the blend factor
      a    = full ? alpha[6:0] : {alpha[6:5], 5'h00};
      prod = 18'(diff * signed'({1'b0, a}));
      if (alpha[7]) begin
         blend = ovl;
      end else begin
         blend = 8'(10'(signed'({2'b00, img})) + 10'(prod >>> 7));
      end
   endfunction : blend

   function automatic logic [7:0] clip(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
      if (v <= lo) begin
         clip = lo;
      end else if (v >= hi) begin
         clip = hi;
      end else begin
         clip = v;
      end
   endfunction : clip

   // ------------------------------------------------------------
   // settings
   // ------------------------------------------------------------
   output_limit_t limits;
   logic          unit_on;
   logic          key_on;
   logic          full_on;
   logic          clip_on;

   assign unit_on = i_unit_control_reg[`CTL_UNIT_ENABLE_BIT];
   assign key_on  = unit_on && i_unit_control_reg[`CTL_KEY_ENABLE_BIT];
   assign full_on = unit_on && i_unit_control_reg[`CTL_FULL_BLEND_BIT];
   assign clip_on = i_unit_control_reg[`CTL_CLIP_ENABLE_BIT];

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         limits.luma_floor     <= `LUMA_FLOOR_RESET;
         limits.luma_ceiling   <= `LUMA_CEILING_RESET;
         limits.chroma_floor   <= `CHROMA_FLOOR_RESET;
         limits.chroma_ceiling <= `CHROMA_CEILING_RESET;
      end else if (i_limit_load) begin
         limits <= i_output_limit_reg;
      end
   end

   assign o_output_limit_reg = limits;

   // read-only status; only the unit identity bit is defined here
   always_comb begin
      o_output_status_reg = '0;
      o_output_status_reg[`STATUS_UNIT_ID_BIT] = 1'b1;
   end

   // ------------------------------------------------------------
   // stage 1: key and blend
   // ------------------------------------------------------------
   composite_in_t d;
   pixel_pair_t   mixed;
   logic [7:0]    ym;
   logic [7:0]    cm;
   logic          keyed;
   logic [7:0]    alpha_first;
   logic [7:0]    alpha_second;
   logic          stall;
   logic          s1_valid;
   logic          s1_in_picture;
   pixel_pair_t   s1_pair;

   assign d  = i_in_data;
   assign ym = ignore_mask(i_match_ignore_reg.luma_ignore_lsbs);
   assign cm = ignore_mask(i_match_ignore_reg.chroma_ignore_lsbs);

   always_comb begin
      // pair-wide key on the first luma and the shared chroma
      keyed = key_on
         && ((d.overlay.y0 & ym) == (i_transparent_match_reg.key_y & ym))
         && ((d.overlay.u & cm) == (i_transparent_match_reg.key_u & cm))
         && ((d.overlay.v & cm) == (i_transparent_match_reg.key_v & cm));
      alpha_first  = d.overlay.u[0] ? i_alpha_one : i_alpha_zero;
      alpha_second = d.overlay.v[0] ? i_alpha_one : i_alpha_zero;
      mixed.y0 = blend(alpha_first, d.overlay.y0, d.image.y0, full_on);
      mixed.u  = blend(alpha_first, d.overlay.u, d.image.u, full_on);
      mixed.v  = blend(alpha_first, d.overlay.v, d.image.v, full_on);
      mixed.y1 = blend(alpha_second, d.overlay.y1, d.image.y1, full_on);
      if (keyed) begin
         mixed = d.image;
      end
   end

   // ------------------------------------------------------------
   // stage 2: clipping, then fifo
   // ------------------------------------------------------------
   logic          fifo_ready;
   logic          s2_valid;
   pixel_pair_t   s2_pair;
   pixel_pair_t   clipped;
   logic [7:0]    ylo;
   logic [7:0]    yhi;
   logic [7:0]    clo;
   logic [7:0]    chi;

   // whole pipe halts on fifo back-pressure
   assign stall      = !fifo_ready;
   assign o_in_ready = !stall;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         s1_valid      <= 1'b0;
         s1_in_picture <= 1'b0;
         s1_pair       <= '0;
      end else if (!stall) begin
         s1_valid      <= i_in_valid;
         s1_in_picture <= d.in_picture;
         s1_pair       <= mixed;
      end
   end

   always_comb begin
      // limits 0 and 255 make every compare pass through unchanged
      ylo = clip_on ? limits.luma_floor     : `FIXED_CLIP_LOW;
      yhi = clip_on ? limits.luma_ceiling   : `FIXED_CLIP_HIGH;
      clo = clip_on ? limits.chroma_floor   : `FIXED_CLIP_LOW;
      chi = clip_on ? limits.chroma_ceiling : `FIXED_CLIP_HIGH;
      clipped = s1_pair;
      if (s1_in_picture) begin
         clipped.y0 = clip(s1_pair.y0, ylo, yhi);
         clipped.y1 = clip(s1_pair.y1, ylo, yhi);
         clipped.u  = clip(s1_pair.u, clo, chi);
         clipped.v  = clip(s1_pair.v, clo, chi);
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         s2_valid <= 1'b0;
         s2_pair  <= '0;
      end else if (!stall) begin
         s2_valid <= s1_valid;
         s2_pair  <= clipped;
      end
   end

   pair_fifo #(
      .WIDTH ($bits(pixel_pair_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_out_fifo (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_in_valid  (s2_valid),
      .o_in_ready  (fifo_ready),
      .i_in_data   (s2_pair),
      .o_out_valid (o_out_valid),
      .i_out_ready (i_out_ready),
      .o_out_data  (o_out_data)
   );
endmodule : video_overlay_compositor
`default_nettype wire

// ==== design/compositor_defs.svh ====
/*
 * Constants for the overlay compositor: control field positions, reset values,
 * fixed clip range and status bits.
 * Assumes it is included by the package and the design module only.
 */
// Behaviour
// - full 129-level blending only when unit and full-blend enables both set; else 25% steps.
// - overlay alpha bit is U LSB for first luma, V LSB for second.
// - alpha bit 0 selects alpha-zero register value, 1 selects alpha-one value.
// - U-byte alpha bit drives U, V and first luma; V-byte bit only second luma.
// - low seven alpha bits give 128 blend levels 0 to 0x7f.
// - alpha MSB set outputs overlay component unchanged.
// - MSB clear: image plus (alpha[6:0]*(overlay-image))>>7.
// - keying only when unit enable and key enable both set.
// - three 8-bit key fields compared with overlay Y, U, V.
// - full unmasked match makes overlay transparent for the whole pair.
// - luma mask ignores zero to four Y LSBs in compare.
// - chroma mask ignores zero to four LSBs of both U and V.
// - programmable clipping with clip enable, as last step after key and blend.
// - clip only inside image areas of active video, never blanking.
// - Y at or below floor forced to floor, at or above ceiling forced.
// - U and V clipped likewise with shared chroma limits.
// - reset limits are 16/235 for luma, 16/240 for chroma.
// - clip enable off clips all components to fixed 16..240.
// - limits 0 and 255 leave components unchanged.
// - status is read-only and bit 4 always reads one.
`ifndef COMPOSITOR_DEFS_SVH
`define COMPOSITOR_DEFS_SVH

`define CTL_UNIT_ENABLE_BIT   0
`define CTL_KEY_ENABLE_BIT    1
`define CTL_FULL_BLEND_BIT    2
`define CTL_CLIP_ENABLE_BIT   3
`define CTL_WIDTH             4

`define LUMA_FLOOR_RESET      8'h10
`define LUMA_CEILING_RESET    8'heb
`define CHROMA_FLOOR_RESET    8'h10
`define CHROMA_CEILING_RESET  8'hf0
`define FIXED_CLIP_LOW        8'h10
`define FIXED_CLIP_HIGH       8'hf0

`define STATUS_WIDTH          8
`define STATUS_UNIT_ID_BIT    4
`define MAX_IGNORE_LSBS       3'h4
`define PIPE_DEPTH            3
`define FIFO_DEPTH_DEFAULT    32

`endif

// ==== design/compositor_pkg.sv ====
/*
 * Types for the overlay compositor: pixel pair carriers and limits.
 * Assumes compositor_defs.svh is on the include path.
 */
`default_nettype none
package compositor_pkg;
   timeunit 1ns;
   timeprecision 1ps;
   `include "compositor_defs.svh"

   // one 4:2:2 pair: first luma, second luma, shared chroma
   typedef struct packed {
      logic [7:0] y0;
      logic [7:0] y1;
      logic [7:0] u;
      logic [7:0] v;
   } pixel_pair_t;

   // background pair plus overlay pair plus region flag
   typedef struct packed {
      pixel_pair_t image;
      pixel_pair_t overlay;
      logic        in_picture;
   } composite_in_t;

   typedef struct packed {
      logic [7:0] luma_floor;
      logic [7:0] luma_ceiling;
      logic [7:0] chroma_floor;
      logic [7:0] chroma_ceiling;
   } output_limit_t;

   typedef struct packed {
      logic [7:0] key_y;
      logic [7:0] key_u;
      logic [7:0] key_v;
   } transparent_match_t;

   typedef struct packed {
      logic [2:0] luma_ignore_lsbs;
      logic [2:0] chroma_ignore_lsbs;
   } match_ignore_t;
endpackage : compositor_pkg
`default_nettype wire

// ==== design/pair_fifo.sv ====
/*
 * Synchronous FIFO with parameterised width and depth, valid/ready both sides.
 * Assumes a single clock and asynchronous active-high reset.
 */
`default_nettype none
module pair_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   // fill side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count != (AW+1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem[rd_ptr];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : pair_fifo
`default_nettype wire

// ==== sim/compositor_monitor.sv ====
/*
 * Checker bound to the overlay compositor: stream timing, limits, pixel results.
 * Assumes pixel checks see pairs that enter an empty pipe and then idle a while.
 */
`default_nettype none
module compositor_monitor
   import compositor_pkg::*;
(
   // clock and reset
   input wire logic               i_clk,
   input wire logic               i_reset,
   // settings and status
   input wire logic [3:0]         i_unit_control_reg,
   input wire logic [7:0]         i_alpha_zero,
   input wire logic [7:0]         i_alpha_one,
   input wire transparent_match_t i_transparent_match_reg,
   input wire logic               i_limit_load,
   input wire output_limit_t      i_output_limit_reg,
   input wire logic [7:0]         o_output_status_reg,
   input wire output_limit_t      o_output_limit_reg,
   // streams
   input wire logic               i_in_valid,
   input wire logic               o_in_ready,
   input wire composite_in_t      i_in_data,
   input wire logic               o_out_valid,
   input wire logic               i_out_ready,
   input wire pixel_pair_t        o_out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // helpers and properties
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   logic        take;
   pixel_pair_t img_t;
   pixel_pair_t ovl_t;
   assign take = i_in_valid && o_in_ready;
   // held until the next take, so the answer may land at either edge
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         img_t <= '0;
         ovl_t <= '0;
      end else if (take) begin
         img_t <= i_in_data.image;
         ovl_t <= i_in_data.overlay;
      end
   end
   function automatic logic in_lim(input pixel_pair_t p, input output_limit_t l);
      return p.y0 >= l.luma_floor && p.y0 <= l.luma_ceiling && p.y1 >= l.luma_floor && p.y1 <= l.luma_ceiling
         && p.u >= l.chroma_floor && p.u <= l.chroma_ceiling && p.v >= l.chroma_floor && p.v <= l.chroma_ceiling;
   endfunction : in_lim
   // only a pair entering an empty pipe has a fixed latency
   sequence s_lone;
      take && !o_out_valid && !$past(take) && !$past(take, 2) && !$past(take, 3);
   endsequence
   sequence s_unkeyed;
      s_lone ##0 (!i_unit_control_reg[1] && !i_in_data.in_picture);
   endsequence
   property p_status;
      o_output_status_reg == 8'h10;
   endproperty
   a_status: assert property (p_status) else $error("status id bit wrong");
   property p_reset_lim;
      $fell(i_reset) |-> o_output_limit_reg == 32'h10eb10f0;
   endproperty
   a_reset_lim: assert property (p_reset_lim) else $error("limit reset value wrong");
   property p_load;
      i_limit_load |=> o_output_limit_reg == $past(i_output_limit_reg);
   endproperty
   a_load: assert property (p_load) else $error("limit load lost");
   property p_hold;
      o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data);
   endproperty
   a_hold: assert property (p_hold) else $error("output changed while stalled");
   property p_latency;
      s_lone ##1 (!take) [*3] |-> ##[0:1] o_out_valid;
   endproperty
   a_latency: assert property (p_latency) else $error("output late");
   property p_key;
      s_lone ##0 (i_unit_control_reg[1:0] == 2'b11 && !i_in_data.in_picture
         && {i_in_data.overlay.y0, i_in_data.overlay.u, i_in_data.overlay.v} == i_transparent_match_reg)
         ##1 (!take) [*3] |-> ##[0:1] (o_out_valid && o_out_data == img_t);
   endproperty
   a_key: assert property (p_key) else $error("keyed pair not image");
   property p_full;
      s_unkeyed ##0 (i_alpha_zero[7] && i_alpha_one[7]) ##1 (!take) [*3]
         |-> ##[0:1] (o_out_valid && o_out_data == ovl_t);
   endproperty
   a_full: assert property (p_full) else $error("full alpha not overlay");
   property p_zero;
      s_unkeyed ##0 (i_alpha_zero == 8'h00 && i_alpha_one == 8'h00) ##1 (!take) [*3]
         |-> ##[0:1] (o_out_valid && o_out_data == img_t);
   endproperty
   a_zero: assert property (p_zero) else $error("zero alpha not image");
   property p_fixed;
      s_lone ##0 (!i_unit_control_reg[3] && i_in_data.in_picture) ##1 (!take) [*3]
         |-> ##[0:1] (o_out_valid && in_lim(o_out_data, 32'h10f010f0));
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed clip range broken");
   property p_prog;
      s_lone ##0 (i_unit_control_reg[3] && i_in_data.in_picture) ##1 (!take) [*3]
         |-> ##[0:1] (o_out_valid && in_lim(o_out_data, o_output_limit_reg));
   endproperty
   a_prog: assert property (p_prog) else $error("programmed clip broken");
endmodule : compositor_monitor
bind video_overlay_compositor compositor_monitor u_monitor (
   .i_clk(i_clk), .i_reset(i_reset), .i_unit_control_reg(i_unit_control_reg),
   .i_alpha_zero(i_alpha_zero), .i_alpha_one(i_alpha_one), .i_transparent_match_reg(i_transparent_match_reg),
   .i_limit_load(i_limit_load), .i_output_limit_reg(i_output_limit_reg), .o_output_status_reg(o_output_status_reg),
   .o_output_limit_reg(o_output_limit_reg), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
   .i_in_data(i_in_data), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_data(o_out_data)
);
`default_nettype wire

// ==== sim/video_overlay_compositor_bench.sv ====
/*
 * Bench for the overlay compositor: single pairs through every control value,
 * three limit sets, then a back-to-back fill of the output buffer.
 * Assumes the checker is bound in by its own file.
 */
`default_nettype none
module video_overlay_compositor_bench
   import compositor_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic               i_clk = 0, i_reset = 1, ld = 0, iv = 0, ordy = 1, ir, ov;
   logic [3:0]         ctl = 0;
   logic [7:0]         a0 = 0, a1 = 0, st;
   transparent_match_t key = 24'h6c935a;
   match_ignore_t      ign = 0;
   output_limit_t      lim = 0, curl = 32'h10eb10f0, lo;
   composite_in_t      din = 0;
   pixel_pair_t        dout;
   pixel_pair_t        q[$];
   int                 failures = 0, n_tests = 0, cyc = 0, r, c, j, n;
   bit                 ok;
   video_overlay_compositor u_dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_unit_control_reg(ctl), .i_alpha_zero(a0), .i_alpha_one(a1),
      .i_transparent_match_reg(key), .i_match_ignore_reg(ign), .i_limit_load(ld), .i_output_limit_reg(lim),
      .o_output_status_reg(st), .o_output_limit_reg(lo), .i_in_valid(iv), .o_in_ready(ir), .i_in_data(din),
      .o_out_valid(ov), .i_out_ready(ordy), .o_out_data(dout));
   // ----------------------------------------
   // reference model and tasks
   // ----------------------------------------
   always #12.5 i_clk = ~i_clk;
   function automatic logic [7:0] bl(input logic [7:0] a, input logic [7:0] o, input logic [7:0] i);
      logic [7:0]         f;
      logic signed [17:0] p;
      f = (ctl[0] && ctl[2]) ? a : (a & 8'he0);
      p = $signed({10'h0, f[6:0]}) * ($signed({10'h0, o}) - $signed({10'h0, i}));
      return f[7] ? o : 8'(i + p[14:7]);
   endfunction : bl
   function automatic logic [7:0] cl(input logic [7:0] x, input logic [7:0] l, input logic [7:0] h, input logic e);
      if (!e) return x;
      if (x <= l) return l;
      return (x >= h) ? h : x;
   endfunction : cl
   function automatic pixel_pair_t ex(input composite_in_t d);
      pixel_pair_t   res;
      output_limit_t lm;
      logic [7:0]    f0, f1, my, mc;
      logic          k;
      f0 = d.overlay.u[0] ? a1 : a0;
      f1 = d.overlay.v[0] ? a1 : a0;
      my = 8'hff << ign.luma_ignore_lsbs;
      mc = 8'hff << ign.chroma_ignore_lsbs;
      k = ctl[0] && ctl[1] && ((d.overlay.y0 ^ key.key_y) & my) == 8'h00
         && (((d.overlay.u ^ key.key_u) | (d.overlay.v ^ key.key_v)) & mc) == 8'h00;
      lm = ctl[3] ? curl : 32'h10f010f0;
      res.y0 = cl(k ? d.image.y0 : bl(f0, d.overlay.y0, d.image.y0), lm.luma_floor, lm.luma_ceiling, d.in_picture);
      res.y1 = cl(k ? d.image.y1 : bl(f1, d.overlay.y1, d.image.y1), lm.luma_floor, lm.luma_ceiling, d.in_picture);
      res.u = cl(k ? d.image.u : bl(f0, d.overlay.u, d.image.u), lm.chroma_floor, lm.chroma_ceiling, d.in_picture);
      res.v = cl(k ? d.image.v : bl(f0, d.overlay.v, d.image.v), lm.chroma_floor, lm.chroma_ceiling, d.in_picture);
      return res;
   endfunction : ex
   // pair 0 equals the key, pair 1 differs from it in masked bits only
   function automatic composite_in_t mk(input int jj);
      case (jj)
         0: return {32'h80f712ee, 32'h6c21935a, 1'b0};
         1: return {32'hb9a45fcf, 32'h6fc8925b, 1'b1};
         2: return {32'hf251aab0, 32'he00331a4, 1'b1};
         default: return {32'h2bfef591, 32'h09fec61f, 1'b1};
      endcase
   endfunction : mk
   task automatic bad(input string m);
      failures++;
      $display("BAD %0t %s", $time, m);
   endtask : bad
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   task automatic send(input int jj, output bit okk);
      int k;
      din <= mk(jj);
      iv <= 1;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (ir !== 1'b1 && k < 8);
      okk = ir === 1'b1;
      if (okk) q.push_back(ex(mk(jj)));
   endtask : send
   task automatic drain;
      int k;
      iv <= 0;
      for (k = 0; k < 100 && q.size() > 0; k++)
         @(posedge i_clk);
      if (q.size() > 0) bad("output missing");
   endtask : drain
   task automatic setl(input output_limit_t v);
      lim <= v;
      ld <= 1;
      @(posedge i_clk);
      ld <= 0;
      curl = v;
      @(posedge i_clk);
      n_tests++;
      if (lo !== v) bad("limit load");
   endtask : setl
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         final_report;
      end
      if (!i_reset && ov === 1'b1 && ordy === 1'b1) begin
         n_tests++;
         if (q.size() == 0) bad("extra output");
         else if (dout !== q.pop_front()) bad("pixel pair");
      end
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_reset <= 0;
      @(posedge i_clk);
      n_tests += 3;
      if (st !== 8'h10) bad("status id");
      if (st[4] !== 1'b1) bad("status id bit");
      if (lo !== 32'h10eb10f0) bad("limit reset");
      for (r = 0; r < 3; r++) begin
         if (r > 0) setl(r == 1 ? 32'h20c030b0 : 32'h00ff00ff);
         for (c = 0; c < 16; c++) begin
            ctl <= 4'(c);
            a0 <= r == 0 ? 8'h00 : (r == 1 ? 8'(32'h20 + c * 5) : 8'h80);
            a1 <= r == 0 ? 8'h00 : (r == 1 ? 8'h7f : 8'hff);
            ign <= {3'(c % 5), 3'(c % 5)};
            @(posedge i_clk);
            for (j = 0; j < 4; j++) begin
               send(j, ok);
               drain;
            end
         end
      end
      // stall the far side so the buffer fills back to back
      ordy <= 0;
      n = 0;
      ok = 1;
      while (ok && n < 50) begin
         send(n % 4, ok);
         if (ok) n++;
      end
      n_tests++;
      if (n < 32 || ov !== 1'b1) bad("buffer fill");
      ordy <= 1;
      drain;
      final_report;
   end
endmodule : video_overlay_compositor_bench
`default_nettype wire
